// ---- hdl/rtp_defs.svh ----
// Constant definitions shared by the real-time trace port design files.
`ifndef RTP_DEFS_SVH
`define RTP_DEFS_SVH

// Widths of the trace nibbles and of one captured value.
`define RTP_NIB_W 4
`define RTP_CAP_W 32
`define RTP_CNT_W 2
`define RTP_NIBS_W 4

// Codes of the processor status nibble; the two reserved codes are never driven.
`define RTP_ST_CONT 4'h0
`define RTP_ST_BEGIN 4'h1
`define RTP_ST_RSVD_A 4'h2
`define RTP_ST_USER 4'h3
`define RTP_ST_PULSE 4'h4
`define RTP_ST_BRANCH 4'h5
`define RTP_ST_RSVD_B 4'h6
`define RTP_ST_RTE 4'h7
`define RTP_ST_MARK_BASE 4'h8
`define RTP_ST_EXC 4'hC
`define RTP_ST_EMU 4'hD
`define RTP_ST_STOP 4'hE
`define RTP_ST_HALT 4'hF

// Event codes presented by the core pipeline each cycle.
`define RTP_EV_CONT 4'h0
`define RTP_EV_BEGIN 4'h1
`define RTP_EV_USER 4'h2
`define RTP_EV_PULSE 4'h3
`define RTP_EV_DEBUG_DATA_WRITE_INSTRUCTION 4'h4
`define RTP_EV_BRANCH 4'h5
`define RTP_EV_SYNC 4'h6
`define RTP_EV_RTE 4'h7
`define RTP_EV_EXC 4'h8
`define RTP_EV_EMU 4'h9
`define RTP_EV_STOP 4'hA
`define RTP_EV_HALT 4'hB

// Branch target display length setting: off, or 2, 3 or 4 bytes.
`define RTP_TGT_OFF 2'h0

// Debug data write operand size: byte, word, longword.
`define RTP_SZ_BYTE 2'h0
`define RTP_SZ_WORD 2'h1
`define RTP_SZ_LONG 2'h2
`define RTP_CNT_WORD 2'h1
`define RTP_CNT_LONG 2'h3

// Buffer depth between the capture side and the shifter.
`define RTP_FIFO_DEPTH 2

`endif

// ---- hdl/rtp_pkg.sv ----
// Types shared by the real-time trace port design files.
package rtp_pkg;

  // Processor modes; all but run hold the status nibble at one code.
  typedef enum logic [2:0] {
    RTP_RUN,
    RTP_EXCEPT,
    RTP_EMULATE,
    RTP_STOPPED,
    RTP_HALTED
  } rtp_mode_t;

endpackage : rtp_pkg

// ---- hdl/rtp_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`include "rtp_defs.svh"

module rtp_fifo
  import rtp_pkg::*;
#(
  parameter int WIDTH = `RTP_CAP_W + `RTP_CNT_W,
  parameter int DEPTH = `RTP_FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointers wrap by plain overflow, so the depth must be a power of two.
  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("rtp_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic push;
  logic pop;

  // Full and empty come from the true occupancy, so back-pressure is exact.
  assign in_ready = (count != (PTR_W+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is written only; it needs no reset as the count guards reads.
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

endmodule : rtp_fifo

// ---- hdl/rtp_trace_port.sv ----
// Real-time trace port: status nibble, debug data nibble and capture buffer.
`timescale 1ns/1ns
`include "rtp_defs.svh"

module rtp_trace_port
  import rtp_pkg::*;
#(
  parameter int NIB_W = `RTP_NIB_W,
  parameter int CAP_W = `RTP_CAP_W,
  parameter int FIFO_DEPTH = `RTP_FIFO_DEPTH
)
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [3:0] CORE_EVENT,
  input wire logic CORE_RESUME,
  input wire logic CAPTURE_VALID,
  input wire logic [CAP_W-1:0] CAPTURE_DATA,
  input wire logic [1:0] CAPTURE_SIZE,
  input wire logic [1:0] BRANCH_TARGET_BYTES,
  input wire logic [NIB_W-1:0] BREAKPOINT_STATUS,
  output logic CORE_STALL,
  output logic [NIB_W-1:0] PROCESSOR_STATUS_NIBBLE,
  output logic [NIB_W-1:0] DEBUG_DATA_NIBBLE,
  output logic COMBINED_HALT_INDICATOR
);

  localparam int ENTRY_W = CAP_W + `RTP_CNT_W;

  // The shifter and markers handle whole bytes of at most four.
  initial
  begin
    if (NIB_W != `RTP_NIB_W || CAP_W != `RTP_CAP_W || FIFO_DEPTH < 2)
      $error("rtp_trace_port: nibble, capture width or depth unsupported");
  end

  // Maps a core event to its status code; reserved codes never come out.
  function automatic logic [3:0] event_code(input logic [3:0] ev);
    logic [3:0] code;
    code = `RTP_ST_CONT;
    case (ev)
      `RTP_EV_CONT: code = `RTP_ST_CONT;
      `RTP_EV_BEGIN: code = `RTP_ST_BEGIN;
      `RTP_EV_USER: code = `RTP_ST_USER;
      `RTP_EV_PULSE: code = `RTP_ST_PULSE;
      `RTP_EV_DEBUG_DATA_WRITE_INSTRUCTION: code = `RTP_ST_PULSE;
      `RTP_EV_BRANCH: code = `RTP_ST_BRANCH;
      `RTP_EV_SYNC: code = `RTP_ST_BRANCH;
      `RTP_EV_RTE: code = `RTP_ST_RTE;
      `RTP_EV_EXC: code = `RTP_ST_EXC;
      `RTP_EV_EMU: code = `RTP_ST_EMU;
      `RTP_EV_STOP: code = `RTP_ST_STOP;
      `RTP_EV_HALT: code = `RTP_ST_HALT;
      default: code = `RTP_ST_CONT;
    endcase
    return code;
  endfunction : event_code

  rtp_mode_t mode;
  rtp_mode_t next_mode;
  logic [3:0] next_status;
  logic [3:0] ev;
  logic cap_take;
  logic [`RTP_CNT_W-1:0] cap_cnt;
  logic pend_valid;
  logic [ENTRY_W-1:0] pend_entry;
  logic next_pend_valid;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [ENTRY_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [ENTRY_W-1:0] fifo_out_data;
  logic [CAP_W-1:0] shift;
  logic [`RTP_NIBS_W-1:0] nibs_left;
  logic marker_due;

  // A stalled core presents nothing new, so its event is read as continue.
  assign ev = CORE_STALL ? `RTP_EV_CONT : CORE_EVENT;

  // Data writes are captured whatever the target setting; branch targets
  // only when display is enabled.
  assign cap_take = CAPTURE_VALID && !CORE_STALL &&
                    ((CORE_EVENT == `RTP_EV_DEBUG_DATA_WRITE_INSTRUCTION) ||
                     (CORE_EVENT == `RTP_EV_BRANCH &&
                      BRANCH_TARGET_BYTES != `RTP_TGT_OFF));

  // Byte count minus one: operand size for writes, setting for branches.
  always_comb
  begin
    cap_cnt = BRANCH_TARGET_BYTES;
    if (CORE_EVENT == `RTP_EV_DEBUG_DATA_WRITE_INSTRUCTION)
    begin
      case (CAPTURE_SIZE)
        `RTP_SZ_BYTE: cap_cnt = '0;
        `RTP_SZ_WORD: cap_cnt = `RTP_CNT_WORD;
        default: cap_cnt = `RTP_CNT_LONG;
      endcase
    end
  end

  // A held capture goes first; while it waits no new capture is taken.
  assign fifo_in_valid = pend_valid || cap_take;
  assign fifo_in_data = pend_valid ? pend_entry : {cap_cnt, CAPTURE_DATA};

  // The pending slot stays filled only while the buffer has no room.
  always_comb
  begin
    if (pend_valid)
      next_pend_valid = !fifo_in_ready;
    else
      next_pend_valid = cap_take && !fifo_in_ready;
  end

  // A marker may only replace a continue cycle in run mode, and only when
  // the shifter is empty or putting out its last nibble this edge.
  assign marker_due = fifo_out_valid && (mode == RTP_RUN) &&
                      (next_mode == RTP_RUN) && (ev == `RTP_EV_CONT) &&
                      (nibs_left <= `RTP_NIBS_W'(1));
  assign fifo_out_ready = marker_due;

  rtp_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .reset_n(RESET_N),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Mode tracking; a halt request wins over everything else.
  always_comb
  begin
    next_mode = mode;
    if (ev == `RTP_EV_HALT)
      next_mode = RTP_HALTED;
    else
    begin
      case (mode)
        RTP_RUN:
        begin
          if (ev == `RTP_EV_EXC)
            next_mode = RTP_EXCEPT;
          else if (ev == `RTP_EV_EMU)
            next_mode = RTP_EMULATE;
          else if (ev == `RTP_EV_STOP)
            next_mode = RTP_STOPPED;
        end
        RTP_EXCEPT,
        RTP_EMULATE,
        RTP_STOPPED,
        RTP_HALTED:
        begin
          if (CORE_RESUME)
            next_mode = RTP_RUN;
        end
        default: next_mode = RTP_RUN;
      endcase
    end
  end

  // Status for the next cycle: held mode code, then marker, then continue on resume, then event.
  always_comb
  begin
    case (next_mode)
      RTP_EXCEPT: next_status = `RTP_ST_EXC;
      RTP_EMULATE: next_status = `RTP_ST_EMU;
      RTP_STOPPED: next_status = `RTP_ST_STOP;
      RTP_HALTED: next_status = `RTP_ST_HALT;
      default:
      begin
        if (marker_due)
          next_status = `RTP_ST_MARK_BASE | {2'h0, fifo_out_data[ENTRY_W-1 -: `RTP_CNT_W]};
        else if (mode != RTP_RUN && CORE_RESUME)
          next_status = `RTP_ST_CONT;
        else
          next_status = event_code(ev);
      end
    endcase
  end

  // Mode register.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      mode <= RTP_RUN;
    else
      mode <= next_mode;
  end

  // Status nibble and halt indicator, both updated every cycle.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      PROCESSOR_STATUS_NIBBLE <= `RTP_ST_CONT;
      COMBINED_HALT_INDICATOR <= 1'b0;
    end
    else
    begin
      PROCESSOR_STATUS_NIBBLE <= next_status;
      COMBINED_HALT_INDICATOR <= &next_status;
    end
  end

  // Pending capture slot and the stall it causes.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pend_valid <= 1'b0;
      pend_entry <= '0;
      CORE_STALL <= 1'b0;
    end
    else
    begin
      pend_valid <= next_pend_valid;
      if (!pend_valid && cap_take)
        pend_entry <= {cap_cnt, CAPTURE_DATA};
      CORE_STALL <= next_pend_valid;
    end
  end

  // Shifter: loaded on the marker edge, so the first nibble shows on the
  // edge after, exactly one cycle behind the marker. Idle cycles pass the
  // breakpoint status through.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      shift <= '0;
      nibs_left <= '0;
      DEBUG_DATA_NIBBLE <= '0;
    end
    else
    begin
      if (nibs_left != '0)
        DEBUG_DATA_NIBBLE <= shift[NIB_W-1:0];
      else
        DEBUG_DATA_NIBBLE <= BREAKPOINT_STATUS;
      if (marker_due)
      begin
        shift <= fifo_out_data[CAP_W-1:0];
        nibs_left <= {1'b0, fifo_out_data[ENTRY_W-1 -: `RTP_CNT_W], 1'b0} + `RTP_NIBS_W'(2);
      end
      else if (nibs_left != '0)
      begin
        shift <= shift >> NIB_W;
        nibs_left <= nibs_left - 1'b1;
      end
    end
  end

endmodule : rtp_trace_port

// ---- bench/rtp_probe.sv ----
// Trace probe model that rebuilds each value shown on the data nibble.
`timescale 1ns/1ns
module rtp_probe
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] stat,
  input wire logic [3:0] dnib,
  output logic got,
  output logic [2:0] nbytes,
  output logic [31:0] value
);
  logic [3:0] left;
  logic [2:0] idx;
  logic [2:0] cur;
  // A marker may share its cycle with the last nibble before it, so the
  // count restarts only after that nibble is stored.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      left <= 4'h0;
      got <= 1'b0;
    end
    else
    begin
      got <= left == 4'h1;
      if (left != 4'h0)
      begin
        value[idx*4 +: 4] <= dnib;
        if (idx == 3'h0)
          value[31:4] <= 28'h0;
        idx <= idx + 3'h1;
        left <= left - 4'h1;
        nbytes <= cur;
      end
      if (stat[3:2] == 2'b10)
      begin
        cur <= 3'(stat[1:0]) + 3'h1;
        left <= 4'({stat[1:0], 1'b0}) + 4'h2;
        idx <= 3'h0;
      end
    end
  end
endmodule : rtp_probe

// ---- bench/rtp_trace_port_properties.sv ----
// Concurrent checks on the trace port outputs.
`timescale 1ns/1ns
module rtp_chk
#(
  parameter int NIB_W = 4,
  parameter int CAP_W = 32
)
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [3:0] CORE_EVENT,
  input wire logic CORE_RESUME,
  input wire logic CAPTURE_VALID,
  input wire logic [CAP_W-1:0] CAPTURE_DATA,
  input wire logic [1:0] CAPTURE_SIZE,
  input wire logic [1:0] BRANCH_TARGET_BYTES,
  input wire logic [NIB_W-1:0] BREAKPOINT_STATUS,
  input wire logic CORE_STALL,
  input wire logic [NIB_W-1:0] PROCESSOR_STATUS_NIBBLE,
  input wire logic [NIB_W-1:0] DEBUG_DATA_NIBBLE,
  input wire logic COMBINED_HALT_INDICATOR
);
  logic [3:0] st;
  logic run;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  // Events map to codes only in run mode, free of stall and resume.
  assign st = PROCESSOR_STATUS_NIBBLE;
  assign run = !CORE_STALL && !CORE_RESUME && st < 4'hC;
  property p_map(logic [3:0] e, logic [3:0] code);
    run && CORE_EVENT == e |=> st == code;
  endproperty
  chk_begin_code: assert property (p_map(4'h1, 4'h1)) else $error("bad");
  chk_user_code: assert property (p_map(4'h2, 4'h3)) else $error("bad");
  chk_pulse_code: assert property (p_map(4'h3, 4'h4)) else $error("bad");
  chk_write_code: assert property (p_map(4'h4, 4'h4)) else $error("bad");
  chk_branch_code: assert property (p_map(4'h5, 4'h5)) else $error("bad");
  chk_sync_code: assert property (p_map(4'h6, 4'h5)) else $error("bad");
  chk_rte_code: assert property (p_map(4'h7, 4'h7)) else $error("bad");
  chk_exc_code: assert property (p_map(4'h8, 4'hC)) else $error("bad");
  chk_emu_code: assert property (p_map(4'h9, 4'hD)) else $error("bad");
  chk_stop_code: assert property (p_map(4'hA, 4'hE)) else $error("bad");
  chk_cont_code: assert property (run && CORE_EVENT == 4'h0 |=> st == 4'h0 || st[3:2] == 2'b10)
    else $error("bad");
  chk_mode_held: assert property (st > 4'hB && st != 4'hF && !CORE_RESUME && CORE_EVENT != 4'hB
    |=> $stable(st)) else $error("bad");
  chk_halt_held: assert property ((st == 4'hF && !CORE_RESUME) || (!CORE_STALL && CORE_EVENT
    == 4'hB) |=> st == 4'hF) else $error("bad");
  chk_no_reserved: assert property (st != 4'h2 && st != 4'h6) else $error("bad");
  chk_halt_and: assert property (COMBINED_HALT_INDICATOR == &st) else $error("bad");
  chk_stall_code: assert property (CORE_STALL && $past(CORE_STALL) |-> st == 4'h0
    || st[3:2] == 2'b10) else $error("bad");
  chk_stall_cause: assert property ($rose(CORE_STALL) |-> $past(CAPTURE_VALID))
    else $error("bad");
  cover property ($rose(CORE_STALL));
  cover property (st[3:2] == 2'b10);
  cover property (COMBINED_HALT_INDICATOR);
endmodule : rtp_chk
bind rtp_trace_port rtp_chk #(.NIB_W(NIB_W), .CAP_W(CAP_W)) i_rtp_chk (
  .CLK(CLK), .RESET_N(RESET_N), .CORE_EVENT(CORE_EVENT), .CORE_RESUME(CORE_RESUME),
  .CAPTURE_VALID(CAPTURE_VALID), .CAPTURE_DATA(CAPTURE_DATA), .CAPTURE_SIZE(CAPTURE_SIZE),
  .BRANCH_TARGET_BYTES(BRANCH_TARGET_BYTES), .BREAKPOINT_STATUS(BREAKPOINT_STATUS),
  .CORE_STALL(CORE_STALL), .PROCESSOR_STATUS_NIBBLE(PROCESSOR_STATUS_NIBBLE),
  .DEBUG_DATA_NIBBLE(DEBUG_DATA_NIBBLE), .COMBINED_HALT_INDICATOR(COMBINED_HALT_INDICATOR));

// ---- bench/rtp_trace_port_tb.sv ----
// Self-checking bench for the trace port with a probe on its outputs.
`timescale 1ns/1ns
module rtp_trace_port_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] ev = 4'h0;
  logic resume = 1'b0;
  logic cap = 1'b0;
  logic [31:0] data = 32'h0;
  logic [1:0] size = 2'h0;
  logic [1:0] cfg = 2'h0;
  logic [3:0] bp = 4'h0;
  logic stall;
  logic [3:0] stat;
  logic [3:0] dnib;
  logic got;
  logic [2:0] nbytes;
  logic [31:0] value;
  logic [34:0] expq[$];
  logic [34:0] exp_v;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;

  rtp_trace_port i_rtp_trace_port (
    .CLK(clk), .RESET_N(reset_n), .CORE_EVENT(ev), .CORE_RESUME(resume),
    .CAPTURE_VALID(cap), .CAPTURE_DATA(data), .CAPTURE_SIZE(size),
    .BRANCH_TARGET_BYTES(cfg), .BREAKPOINT_STATUS(bp), .CORE_STALL(stall),
    .PROCESSOR_STATUS_NIBBLE(stat), .DEBUG_DATA_NIBBLE(dnib), .COMBINED_HALT_INDICATOR());
  rtp_probe i_rtp_probe (.clk(clk), .reset_n(reset_n), .stat(stat), .dnib(dnib),
    .got(got), .nbytes(nbytes), .value(value));

  task automatic test_done();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // One core cycle; the request stands until an edge sees the stall low.
  task automatic step(input logic [3:0] e, input logic c, input logic r);
    logic s;
    logic [2:0] n;
    @(negedge clk);
    ev = e;
    cap = c;
    resume = r;
    data = $urandom;
    size = 2'($urandom);
    cfg = 2'($urandom);
    s = stall;
    @(posedge clk);
    for (int k = 0; k < 40 && s === 1'b1; k++)
    begin
      @(negedge clk);
      s = stall;
      @(posedge clk);
    end
    n = (e == 4'h5) ? 3'(cfg) + 3'h1 : (size == 2'h0) ? 3'h1 : (size == 2'h1) ? 3'h2 : 3'h4;
    if (c && (e == 4'h4 || (e == 4'h5 && cfg != 2'h0)))
      expq.push_back({n, n == 3'h4 ? data : data & ((32'h1 << (8 * n)) - 32'h1)});
  endtask : step

  // Clock at 125 MHz and a cycle ceiling that cuts a hang short.
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      test_done();
    end
  end

  // Each value the probe rebuilds is held against the oldest note.
  always @(posedge clk)
  begin
    if (got === 1'b1)
    begin
      checks_done++;
      exp_v = expq.size() > 0 ? expq.pop_front() : {35{1'bx}};
      if ({nbytes, value} !== exp_v)
      begin
        fails++;
        $display("MISMATCH transfer expected %h seen %h", exp_v, {nbytes, value});
      end
    end
  end

  // Every event code, then dense random captures so the buffer fills.
  initial
  begin
    void'($urandom(32'h6514));
    repeat (6) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    for (int e = 0; e < 12; e++)
    begin
      step(4'(e), 1'b0, 1'b0);
      if (e > 7)
      begin
        repeat (3) step(4'h0, 1'b0, 1'b0);
        step(4'h0, 1'b0, 1'b1);
      end
    end
    for (int i = 0; i < 80; i++)
    begin
      step(i % 3 == 0 ? 4'h1 : 4'($urandom_range(5, 4)), 1'b1, 1'b0);
      repeat ($urandom_range(2)) step(4'h0, 1'b0, 1'b0);
    end
    repeat (40) step(4'h0, 1'b0, 1'b0);
    @(negedge clk);
    bp = 4'($urandom);
    @(negedge clk);
    checks_done++;
    if (dnib !== bp)
    begin
      fails++;
      $display("MISMATCH idle_data expected %h seen %h", bp, dnib);
    end
    checks_done++;
    if (expq.size() != 0)
    begin
      fails++;
      $display("MISMATCH pending expected 0 seen %0d", expq.size());
    end
    test_done();
  end
endmodule : rtp_trace_port_tb
